/* File: bench/rtc_bus_master.sv */
`timescale 1ns/1ns
module rtc_bus_master (
   // clock
   input wire logic core_clk,
   // bus pins
   input wire logic sda_oe,
   output logic scl,
   output logic sda
);
   logic m_oe = 1'b0;
   initial scl = 1'b1;
   // ---------------------------------
   // open drain wire, pulled up
   // ---------------------------------
   assign sda = !(sda_oe || m_oe);
   task automatic q();
      repeat (10) @(posedge core_clk);
   endtask : q
   task automatic start();
      m_oe <= 1'b0;
      q();
      scl <= 1'b1;
      q();
      m_oe <= 1'b1;
      q();
      scl <= 1'b0;
      q();
   endtask : start
   task automatic stop();
      m_oe <= 1'b1;
      q();
      scl <= 1'b1;
      q();
      m_oe <= 1'b0;
      q();
   endtask : stop
   // sda only moves while scl low
   task automatic clk_bit(input logic b, output logic s);
      m_oe <= !b;
      q();
      scl <= 1'b1;
      q();
      s = sda;
      q();
      scl <= 1'b0;
      q();
   endtask : clk_bit
   task automatic send(input logic [7:0] d, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) clk_bit(d[i], s);
      clk_bit(1'b1, s);
      ack = !s;
   endtask : send
   task automatic recv(input logic last, output logic [7:0] d);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         clk_bit(1'b1, s);
         d[i] = s;
      end
      clk_bit(last, s);
   endtask : recv
endmodule : rtc_bus_master

/* File: bench/testbench.sv */
`timescale 1ns/1ns
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin err_count++; \
   $display("wrong value at %0t: got %h exp %h", $time, (g), (e)); end end
module testbench;
   localparam logic [4:0] ID = rtc_pkg::DEV_ID_DFLT;
   localparam logic [7:0] HR_IN [0:2] = '{8'h23, 8'h23, 8'h71};
   localparam logic [7:0] HR_EX [0:2] = '{8'h00, 8'h00, 8'h52};
   localparam logic [7:0] YR [0:2] = '{8'h23, 8'h24, 8'h23};
   localparam logic [7:0] DT_EX [0:2] = '{8'h01, 8'h29, 8'h01};
   localparam logic [7:0] MO_EX [0:2] = '{8'h03, 8'h02, 8'h03};
   logic core_clk = 1'b0;
   logic reset = 1'b1;
   logic tick_4k = 1'b0;
   logic vcc_ok = 1'b0;
   logic osc_stop = 1'b0;
   logic scl, sda, sda_oe, rst_n_oe, charger_en, osc_off, k, sda_o, rst_o;
   logic [1:0] dsel, rsel;
   int err_count = 0;
   int total_checks = 0;
   initial forever #2 core_clk = ~core_clk;
   rtc_bus_master m (.core_clk(core_clk), .sda_oe(sda_oe), .scl(scl), .sda(sda));
   // short hold so the blocked window fits one address byte
   rtc_core #(.DEV_ID(ID), .RST_HOLD_CYC(600)) uut (.core_clk(core_clk), .reset(reset), .scl_in(scl),
      .sda_in(sda), .sda_out(sda_o), .sda_oe(sda_oe), .tick_4k_in(tick_4k), .vcc_ok_in(vcc_ok),
      .osc_stop_in(osc_stop), .rst_n_out(rst_o), .rst_n_oe(rst_n_oe), .charger_en(charger_en),
      .diode_select_bits(dsel), .resistor_select_bits(rsel), .osc_off_on_battery(osc_off));
   task automatic stop_test();
      $display("checks %0d mismatches %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : stop_test
   task automatic ticks(input int n);
      repeat (n) begin
         repeat (4) @(posedge core_clk);
         tick_4k <= 1'b1;
         repeat (4) @(posedge core_clk);
         tick_4k <= 1'b0;
      end
   endtask : ticks
   task automatic wr(input logic [1:0] b, input logic [7:0] a, input logic [7:0] d [$]);
      m.start();
      m.send({ID, b, 1'b0}, k);
      `CHK(k, 1'b1)
      m.send(a, k);
      foreach (d[i]) m.send(d[i], k);
      m.stop();
   endtask : wr
   task automatic rd(input logic [1:0] b, input logic [7:0] a, input logic [7:0] e [$]);
      logic [7:0] v;
      m.start();
      m.send({ID, b, 1'b0}, k);
      m.send(a, k);
      m.start();
      m.send({ID, b, 1'b1}, k);
      `CHK(k, 1'b1)
      foreach (e[i]) begin
         m.recv(i == e.size() - 1, v);
         `CHK(v, e[i])
      end
      m.stop();
   endtask : rd
   task automatic probe(input logic [1:0] b);
      m.start();
      m.send({ID, b, 1'b0}, k);
      m.stop();
   endtask : probe
   // ---------------------------------
   // bounded run
   // ---------------------------------
   initial begin
      #360000;
      err_count++;
      $display("wrong value at %0t: timeout", $time);
      stop_test();
   end
   initial begin
      repeat (20) @(posedge core_clk);
      reset <= 1'b0;
      probe(2'h0);
      `CHK(k, 1'b0)
      `CHK(rst_n_oe, 1'b1)
      vcc_ok <= 1'b1;
      probe(2'h0);
      `CHK(k, 1'b0)
      `CHK(rst_n_oe, 1'b1)
      for (int i = 0; i < 2000 && rst_n_oe !== 1'b0; i++) @(posedge core_clk);
      `CHK(rst_n_oe, 1'b0)
      `CHK({sda_o, rst_o}, 2'b00)
      $display("test power done");
      wr(0, 8'h08, '{8'h34, 8'h12});
      rd(0, 8'h08, '{8'h34, 8'h12});
      wr(0, 8'h0A, '{8'hA6, 8'hFF, 8'hFC, 8'h42});
      `CHK({charger_en, dsel, rsel, osc_off}, 6'b1_01_10_1)
      rd(0, 8'h0A, '{8'hA6, 8'h80, 8'h80, 8'h42});
      wr(0, 8'h0A, '{8'hB6, 8'h00});
      `CHK(charger_en, 1'b0)
      rd(0, 8'h0B, '{8'h00});
      osc_stop <= 1'b1;
      repeat (8) @(posedge core_clk);
      osc_stop <= 1'b0;
      rd(0, 8'h0B, '{8'h80});
      $display("test control done");
      for (int c = 0; c < 3; c++) begin
         wr(0, 8'h00, '{8'h99, 8'h59, 8'h59, HR_IN[c], 8'h07, 8'h28, 8'h02, YR[c]});
         ticks(45);
         rd(0, 8'h01, '{8'h00, 8'h00, HR_EX[c], 8'h01, DT_EX[c], MO_EX[c], YR[c]});
      end
      $display("test calendar done");
      wr(1, 8'hFE, '{8'h11, 8'h22, 8'h33});
      wr(2, 8'h00, '{8'h44});
      wr(1, 8'h00, '{8'h55});
      rd(1, 8'hFE, '{8'h11, 8'h22, 8'h55});
      rd(1, 8'hF8, '{8'h33});
      rd(2, 8'h00, '{8'h44});
      probe(2'h3);
      `CHK(k, 1'b0)
      $display("test storage done");
      vcc_ok <= 1'b0;
      probe(2'h0);
      `CHK(k, 1'b0)
      `CHK(rst_n_oe, 1'b1)
      $display("test supply drop done");
      stop_test();
   end
endmodule : testbench

/* File: design/rtc_core.sv */
`timescale 1ns/1ns
module rtc_core #(
   parameter logic [4:0] DEV_ID = rtc_pkg::DEV_ID_DFLT,
   parameter int RST_HOLD_CYC = rtc_pkg::RST_HOLD_CYC
) (
   // clock and reset
   input wire logic core_clk,
   input wire logic reset,
   // serial bus pins
   input wire logic scl_in,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe,
   // timebase and supply monitor
   input wire logic tick_4k_in,
   input wire logic vcc_ok_in,
   input wire logic osc_stop_in,
   // reset pin, open drain
   output logic rst_n_out,
   output logic rst_n_oe,
   // charger and oscillator controls
   output logic charger_en,
   output logic [1:0] diode_select_bits,
   output logic [1:0] resistor_select_bits,
   output logic osc_off_on_battery
);
   localparam int HW = $clog2(RST_HOLD_CYC + 1);

   // ---------------------------------------------------------
   // input synchronisers
   // ---------------------------------------------------------
   logic [4:0] sync1_r, sync2_r, sync3_r;
   always_ff @(posedge core_clk) begin
      if (reset) begin
         sync1_r <= 5'h03;
         sync2_r <= 5'h03;
         sync3_r <= 5'h03;
      end else begin
         sync1_r <= {osc_stop_in, vcc_ok_in, tick_4k_in, sda_in, scl_in};
         sync2_r <= sync1_r;
         sync3_r <= sync2_r;
      end
   end

   logic scl_rise, scl_fall, start_det, stop_det;
   logic sda_s, tick_edge, pwr_ok, osc_edge;
   assign scl_rise = sync2_r[0] & ~sync3_r[0];
   assign scl_fall = ~sync2_r[0] & sync3_r[0];
   assign start_det = sync2_r[0] & sync3_r[0] & ~sync2_r[1] & sync3_r[1];
   assign stop_det = sync2_r[0] & sync3_r[0] & sync2_r[1] & ~sync3_r[1];
   assign sda_s = sync2_r[1];
   assign tick_edge = sync2_r[2] & ~sync3_r[2];
   assign pwr_ok = sync2_r[3];
   assign osc_edge = sync2_r[4] & ~sync3_r[4];

   // ---------------------------------------------------------
   // power fail and reset output
   // ---------------------------------------------------------
   logic [HW-1:0] hold_r;
   logic rst_active, access_ok, wd_fire;
   always_ff @(posedge core_clk) begin
      if (reset) begin
         hold_r <= HW'(RST_HOLD_CYC);
      end else if (!pwr_ok || wd_fire) begin
         hold_r <= HW'(RST_HOLD_CYC);
      end else if (hold_r != '0) begin
         hold_r <= hold_r - 1'b1;
      end
   end
   assign rst_active = !pwr_ok || hold_r != '0;
   assign access_ok = !rst_active;
   assign rst_n_oe = rst_active;
   assign rst_n_out = 1'b0;

   // ---------------------------------------------------------
   // hundredths generator
   // ---------------------------------------------------------
   logic [5:0] div_r;
   logic [4:0] run_r;
   logic hund_tick;
   assign hund_tick = tick_edge &&
      div_r == ((run_r == rtc_pkg::DIV_RUNS) ? rtc_pkg::DIV_SHORT : rtc_pkg::DIV_LONG) - 6'h01;
   always_ff @(posedge core_clk) begin
      if (reset) begin
         div_r <= '0;
         run_r <= '0;
      end else if (hund_tick) begin
         div_r <= '0;
         run_r <= (run_r == rtc_pkg::DIV_RUNS) ? '0 : run_r + 5'h01;
      end else if (tick_edge) begin
         div_r <= div_r + 6'h01;
      end
   end

   // ---------------------------------------------------------
   // helpers
   // ---------------------------------------------------------
   function automatic logic [7:0] bcd_inc(input logic [7:0] v);
      bcd_inc = (v[3:0] == 4'h9) ? {v[7:4] + 4'h1, 4'h0} : {v[7:4], v[3:0] + 4'h1};
   endfunction : bcd_inc

   function automatic logic [7:0] last_date(input logic [7:0] mon, input logic [7:0] yr);
      logic leap;
      // 2000 is leap, so the 4-year rule holds to 2099
      leap = yr[4] ? (yr[3:0] == 4'h2 || yr[3:0] == 4'h6) :
         (yr[3:0] == 4'h0 || yr[3:0] == 4'h4 || yr[3:0] == 4'h8);
      if (mon[4:0] == 5'h02) last_date = leap ? 8'h29 : 8'h28;
      else if (mon[4:0] inside {5'h04, 5'h06, 5'h09, 5'h11}) last_date = 8'h30;
      else last_date = 8'h31;
   endfunction : last_date

   function automatic logic [15:0] bcd_dec4(input logic [15:0] v);
      logic [15:0] r;
      logic b;
      r = v;
      b = 1'b1;
      for (int i = 0; i < 4; i++) begin
         if (b) begin
            if (r[4*i +: 4] == 4'h0) begin
               r[4*i +: 4] = 4'h9;
            end else begin
               r[4*i +: 4] = r[4*i +: 4] - 4'h1;
               b = 1'b0;
            end
         end
      end
      bcd_dec4 = r;
   endfunction : bcd_dec4

   function automatic logic [7:0] ptr_step(input logic [1:0] b, input logic [7:0] p, input logic wr);
      if (b == rtc_pkg::BLK_TIME) ptr_step = (p >= rtc_pkg::OFS_CONTROL) ? 8'h00 : p + 8'h01;
      else if (wr) ptr_step = {p[7:3], p[2:0] + 3'h1};
      else ptr_step = p + 8'h01;
   endfunction : ptr_step

   // ---------------------------------------------------------
   // bus slave state
   // ---------------------------------------------------------
   rtc_pkg::rtc_state_t state_r;
   logic [3:0] cnt_r;
   logic [7:0] sh_r, tx_r, ptr_r, ptr_inc, rd_byte;
   logic [1:0] blk_r;
   logic rw_r, wr_go, ptr_adv, tm_we, blk0;
   logic [7:0] tm_r [0:7];
   logic [7:0] tm_nxt [0:7];
   logic [7:0] snap_r [0:7];
   logic [7:0] nv_mem [0:511];
   logic [15:0] wd_r, wd_seed_r;
   logic [7:0] chg_r;
   logic osf_r, wf_r, osc_off_on_battery_r, wde_r, wdrst_r, wd_zero;

   assign blk0 = blk_r == rtc_pkg::BLK_TIME;
   assign ptr_inc = ptr_step(blk_r, ptr_r, !rw_r);
   assign wr_go = state_r == rtc_pkg::ST_WR && scl_fall && cnt_r == rtc_pkg::BITS_PER_BYTE && access_ok;
   assign ptr_adv = scl_fall && access_ok && (state_r == rtc_pkg::ST_DACK ||
      (state_r == rtc_pkg::ST_RD && cnt_r == rtc_pkg::BITS_PER_BYTE));
   assign tm_we = wr_go && blk0 && ptr_r < rtc_pkg::OFS_WD_FRACTION;

   always_ff @(posedge core_clk) begin
      if (reset) begin
         state_r <= rtc_pkg::ST_IDLE;
         cnt_r <= '0;
         sh_r <= '0;
         tx_r <= 8'hFF;
         ptr_r <= '0;
         blk_r <= '0;
         rw_r <= 1'b0;
      end else if (!access_ok) begin
         state_r <= rtc_pkg::ST_IDLE;
      end else if (start_det) begin
         state_r <= rtc_pkg::ST_ADDR;
         cnt_r <= '0;
      end else if (stop_det) begin
         state_r <= rtc_pkg::ST_IDLE;
      end else begin
         if (scl_rise && state_r inside {rtc_pkg::ST_ADDR, rtc_pkg::ST_WORD, rtc_pkg::ST_WR,
            rtc_pkg::ST_RACK}) begin
            sh_r <= {sh_r[6:0], sda_s};
         end
         if (scl_rise && state_r inside {rtc_pkg::ST_ADDR, rtc_pkg::ST_WORD, rtc_pkg::ST_WR,
            rtc_pkg::ST_RD}) begin
            cnt_r <= cnt_r + 4'h1;
         end
         if (scl_fall) begin
            unique case (state_r)
               rtc_pkg::ST_IDLE: begin
               end
               rtc_pkg::ST_ADDR: begin
                  if (cnt_r == rtc_pkg::BITS_PER_BYTE) begin
                     if (sh_r[7:3] == DEV_ID && sh_r[2:1] != rtc_pkg::BLK_NONE) begin
                        state_r <= rtc_pkg::ST_AACK;
                        blk_r <= sh_r[2:1];
                        rw_r <= sh_r[0];
                     end else begin
                        state_r <= rtc_pkg::ST_IDLE;
                     end
                  end
               end
               rtc_pkg::ST_AACK: begin
                  cnt_r <= '0;
                  if (rw_r) begin
                     state_r <= rtc_pkg::ST_RD;
                     tx_r <= rd_byte;
                  end else begin
                     state_r <= rtc_pkg::ST_WORD;
                  end
               end
               rtc_pkg::ST_WORD: begin
                  if (cnt_r == rtc_pkg::BITS_PER_BYTE) begin
                     state_r <= rtc_pkg::ST_WACK;
                     ptr_r <= sh_r;
                  end
               end
               rtc_pkg::ST_WACK: begin
                  cnt_r <= '0;
                  state_r <= rtc_pkg::ST_WR;
               end
               rtc_pkg::ST_WR: begin
                  if (cnt_r == rtc_pkg::BITS_PER_BYTE) state_r <= rtc_pkg::ST_DACK;
               end
               rtc_pkg::ST_DACK: begin
                  cnt_r <= '0;
                  ptr_r <= ptr_inc;
                  state_r <= rtc_pkg::ST_WR;
               end
               rtc_pkg::ST_RD: begin
                  if (cnt_r == rtc_pkg::BITS_PER_BYTE) begin
                     state_r <= rtc_pkg::ST_RACK;
                     ptr_r <= ptr_inc;
                  end else begin
                     tx_r <= {tx_r[6:0], 1'b1};
                  end
               end
               // master nack ends the read
               rtc_pkg::ST_RACK: begin
                  cnt_r <= '0;
                  if (!sh_r[0]) begin
                     state_r <= rtc_pkg::ST_RD;
                     tx_r <= rd_byte;
                  end else begin
                     state_r <= rtc_pkg::ST_IDLE;
                  end
               end
            endcase
         end
      end
   end

   assign sda_oe = state_r inside {rtc_pkg::ST_AACK, rtc_pkg::ST_WACK, rtc_pkg::ST_DACK} ||
      (state_r == rtc_pkg::ST_RD && !tx_r[7]);
   assign sda_out = 1'b0;

   // ---------------------------------------------------------
   // read data
   // ---------------------------------------------------------
   // time registers read from the snapshot, other registers and storage read live
   always_comb begin
      rd_byte = 8'h00;
      if (blk0) begin
         if (ptr_r < rtc_pkg::OFS_WD_FRACTION) begin
            rd_byte = snap_r[ptr_r[2:0]];
         end else begin
            case (ptr_r)
               rtc_pkg::OFS_WD_FRACTION: rd_byte = wd_r[7:0];
               rtc_pkg::OFS_WD_WHOLE: rd_byte = wd_r[15:8];
               rtc_pkg::OFS_CHARGER: rd_byte = chg_r;
               rtc_pkg::OFS_FLAGS: rd_byte = {osf_r, wf_r, 6'h00};
               rtc_pkg::OFS_CONTROL: rd_byte = {osc_off_on_battery_r, 5'h00, wde_r, wdrst_r};
               default: rd_byte = 8'h00;
            endcase
         end
      end else if (blk_r != rtc_pkg::BLK_NONE) begin
         rd_byte = nv_mem[{blk_r[1], ptr_r}];
      end
   end

   always_ff @(posedge core_clk) begin
      if (wr_go && !blk0) nv_mem[{blk_r[1], ptr_r}] <= sh_r;
   end

   // ---------------------------------------------------------
   // time and calendar
   // ---------------------------------------------------------
   // carry chain
   always_comb begin
      logic c;
      logic [7:0] t;
      c = hund_tick;
      t = 8'h00;
      tm_nxt = tm_r;
      if (c) begin
         c = tm_r[0] == 8'h99;
         tm_nxt[0] = c ? 8'h00 : bcd_inc(tm_r[0]);
      end
      if (c) begin
         c = tm_r[1] == 8'h59;
         tm_nxt[1] = c ? 8'h00 : bcd_inc(tm_r[1]);
      end
      if (c) begin
         c = tm_r[2] == 8'h59;
         tm_nxt[2] = c ? 8'h00 : bcd_inc(tm_r[2]);
      end
      if (c) begin
         if (tm_r[3][rtc_pkg::HR_12H_BIT]) begin
            t = bcd_inc({3'h0, tm_r[3][4:0]});
            c = tm_r[3][rtc_pkg::HR_PM_BIT] && tm_r[3][4:0] == 5'h11;
            if (tm_r[3][4:0] == 5'h11) tm_nxt[3][rtc_pkg::HR_PM_BIT] = ~tm_r[3][rtc_pkg::HR_PM_BIT];
            tm_nxt[3][4:0] = (tm_r[3][4:0] == 5'h12) ? 5'h01 : t[4:0];
         end else begin
            t = bcd_inc({2'h0, tm_r[3][5:0]});
            c = tm_r[3][5:0] == 6'h23;
            tm_nxt[3][5:0] = c ? 6'h00 : t[5:0];
         end
      end
      if (c) begin
         tm_nxt[4][2:0] = (tm_r[4][2:0] == 3'h7) ? 3'h1 : tm_r[4][2:0] + 3'h1;
         t = last_date(tm_r[6], tm_r[7]);
         c = tm_r[5] == t;
         tm_nxt[5] = c ? 8'h01 : bcd_inc(tm_r[5]);
      end
      if (c) begin
         t = bcd_inc({3'h0, tm_r[6][4:0]});
         c = tm_r[6][4:0] == 5'h12;
         tm_nxt[6][4:0] = c ? 5'h01 : t[4:0];
      end
      if (c) tm_nxt[7] = (tm_r[7] == 8'h99) ? 8'h00 : bcd_inc(tm_r[7]);
      if (tm_we) tm_nxt[ptr_r[2:0]] = sh_r & rtc_pkg::TM_MASK[ptr_r[2:0]];
   end

   // defined start only for the bench's sake
   always_ff @(posedge core_clk) begin
      for (int i = 0; i < 8; i++) begin
         if (reset) tm_r[i] <= rtc_pkg::TM_RST[8*i +: 8];
         else tm_r[i] <= tm_nxt[i];
      end
   end

   always_ff @(posedge core_clk) begin
      if (reset || start_det || (ptr_adv && blk0 && ptr_inc == rtc_pkg::OFS_HUNDREDTHS)) begin
         snap_r <= tm_r;
      end
   end

   // ---------------------------------------------------------
   // watchdog, flags, control, charger
   // ---------------------------------------------------------
   logic we_wdf, we_wdw, we_chg, we_flg, we_ctl;
   assign we_wdf = wr_go && blk0 && ptr_r == rtc_pkg::OFS_WD_FRACTION;
   assign we_wdw = wr_go && blk0 && ptr_r == rtc_pkg::OFS_WD_WHOLE;
   assign we_chg = wr_go && blk0 && ptr_r == rtc_pkg::OFS_CHARGER;
   assign we_flg = wr_go && blk0 && ptr_r == rtc_pkg::OFS_FLAGS;
   assign we_ctl = wr_go && blk0 && ptr_r == rtc_pkg::OFS_CONTROL;
   assign wd_zero = hund_tick && wde_r && wd_r == 16'h0001 && !we_wdf && !we_wdw;
   assign wd_fire = wd_zero && wdrst_r;

   // two BCD bytes, write loads seed and count
   always_ff @(posedge core_clk) begin
      if (reset) begin
         wd_r <= 16'h0000;
         wd_seed_r <= 16'h0000;
      end else if (we_wdf) begin
         wd_seed_r[7:0] <= sh_r;
         wd_r <= {wd_seed_r[15:8], sh_r};
      end else if (we_wdw) begin
         wd_seed_r[15:8] <= sh_r;
         wd_r <= {sh_r, wd_seed_r[7:0]};
      end else if (hund_tick && wde_r && wd_r != 16'h0000) begin
         wd_r <= bcd_dec4(wd_r);
      end
   end

   // set wins, clear only by zero
   always_ff @(posedge core_clk) begin
      if (reset) begin
         osf_r <= 1'b1;
         wf_r <= 1'b0;
      end else begin
         if (osc_edge) osf_r <= 1'b1;
         else if (we_flg && !sh_r[7]) osf_r <= 1'b0;
         if (wd_zero) wf_r <= 1'b1;
         else if (we_flg && !sh_r[6]) wf_r <= 1'b0;
      end
   end

   always_ff @(posedge core_clk) begin
      if (reset) begin
         osc_off_on_battery_r <= 1'b0;
         wde_r <= 1'b0;
         wdrst_r <= 1'b0;
         chg_r <= rtc_pkg::CHG_RST;
      end else begin
         if (we_ctl) {osc_off_on_battery_r, wde_r, wdrst_r} <= {sh_r[7], sh_r[1:0]};
         if (we_chg) chg_r <= sh_r;
      end
   end

   assign charger_en = chg_r[7:4] == rtc_pkg::CHG_KEY;
   assign diode_select_bits = chg_r[3:2];
   assign resistor_select_bits = chg_r[1:0];
   assign osc_off_on_battery = osc_off_on_battery_r;

   // ---------------------------------------------------------
   // assertions
   // ---------------------------------------------------------
   logic [5:0] tk_cnt_r;
   always_ff @(posedge core_clk) begin
      if (reset || hund_tick) tk_cnt_r <= '0;
      else if (tick_edge) tk_cnt_r <= tk_cnt_r + 6'h01;
   end

   a_pf_no_ack: assert property (@(posedge core_clk) disable iff (reset)
      !pwr_ok |=> state_r == rtc_pkg::ST_IDLE && !sda_oe) else $error("access during power fail");
   a_write_gate: assert property (@(posedge core_clk) disable iff (reset)
      wr_go |-> !rst_n_oe && pwr_ok) else $error("write while reset active");
   a_rst_on_fail: assert property (@(posedge core_clk) disable iff (reset)
      $fell(pwr_ok) |-> rst_n_oe [*2]) else $error("reset not held on fail");
   a_tm_wrap: assert property (@(posedge core_clk) disable iff (reset)
      ptr_adv && blk0 && ptr_r == rtc_pkg::OFS_CONTROL |=> ptr_r == 8'h00) else $error("time wrap");
   a_snap_copy: assert property (@(posedge core_clk) disable iff (reset)
      start_det |=> snap_r[1] == $past(tm_r[1]) && snap_r[3] == $past(tm_r[3])) else $error("snapshot");
   a_nv_rd_wrap: assert property (@(posedge core_clk) disable iff (reset)
      ptr_adv && rw_r && !blk0 && ptr_r == 8'hFF |=> ptr_r == 8'h00) else $error("read wrap");
   a_page_wrap: assert property (@(posedge core_clk) disable iff (reset)
      ptr_adv && !rw_r && !blk0 && ptr_r[2:0] == 3'h7 |=> ptr_r[2:0] == 3'h0 &&
      ptr_r[7:3] == $past(ptr_r[7:3])) else $error("page wrap");
   a_tick_period: assert property (@(posedge core_clk) disable iff (reset)
      hund_tick |-> tk_cnt_r == 6'h28 || (tk_cnt_r == 6'h27 && run_r == rtc_pkg::DIV_RUNS))
      else $error("tick period");
   a_osf_keep: assert property (@(posedge core_clk) disable iff (reset)
      we_flg && sh_r[7] && osf_r |=> osf_r) else $error("flag cleared by one");
   a_charger_key: assert property (@(posedge core_clk) disable iff (reset)
      we_chg && sh_r[7:4] != 4'hA |=> !charger_en) else $error("charger enabled");
   a_sec_roll: assert property (@(posedge core_clk) disable iff (reset)
      hund_tick && !tm_we && tm_r[0] == 8'h99 && tm_r[1] == 8'h59 |=> tm_r[0] == 8'h00 &&
      tm_r[1] == 8'h00) else $error("seconds carry");

   c_time_write: cover property (@(posedge core_clk) disable iff (reset) tm_we);
   c_read_next: cover property (@(posedge core_clk) disable iff (reset)
      state_r == rtc_pkg::ST_RACK ##1 state_r == rtc_pkg::ST_RD);
   c_short_div: cover property (@(posedge core_clk) disable iff (reset)
      hund_tick && run_r == rtc_pkg::DIV_RUNS);
   c_nv_write: cover property (@(posedge core_clk) disable iff (reset) wr_go && !blk0);
endmodule : rtc_core

/* File: design/rtc_pkg.sv */
package rtc_pkg;
   // ---------------------------------------------------------
   // address map, block 0
   // ---------------------------------------------------------
   localparam logic [7:0] OFS_HUNDREDTHS = 8'h00;
   localparam logic [7:0] OFS_SECONDS = 8'h01;
   localparam logic [7:0] OFS_MINUTES = 8'h02;
   localparam logic [7:0] OFS_HOURS = 8'h03;
   localparam logic [7:0] OFS_WEEKDAY = 8'h04;
   localparam logic [7:0] OFS_MONTH_DAY = 8'h05;
   localparam logic [7:0] OFS_MONTH = 8'h06;
   localparam logic [7:0] OFS_YEAR = 8'h07;
   localparam logic [7:0] OFS_WD_FRACTION = 8'h08;
   localparam logic [7:0] OFS_WD_WHOLE = 8'h09;
   localparam logic [7:0] OFS_CHARGER = 8'h0A;
   localparam logic [7:0] OFS_FLAGS = 8'h0B;
   localparam logic [7:0] OFS_CONTROL = 8'h0C;
   localparam logic [1:0] BLK_TIME = 2'h0;
   localparam logic [1:0] BLK_NONE = 2'h3;
   // ---------------------------------------------------------
   // fields and reset values
   // ---------------------------------------------------------
   localparam int HR_12H_BIT = 6;
   localparam int HR_PM_BIT = 5;
   localparam logic [3:0] CHG_KEY = 4'hA;
   localparam logic [7:0] CHG_RST = 8'h00;
   localparam logic [63:0] TM_RST = 64'h0001010100000000;
   // fixed-zero bits masked on write, per time index
   localparam logic [7:0] TM_MASK [0:7] = '{8'hFF, 8'h7F, 8'h7F, 8'h7F, 8'h0F, 8'h3F, 8'h3F, 8'hFF};
   localparam logic [4:0] DEV_ID_DFLT = 5'h0B; // arbitrary value
   // ---------------------------------------------------------
   // counts and timing
   // ---------------------------------------------------------
   localparam logic [3:0] BITS_PER_BYTE = 4'h8;
   localparam logic [5:0] DIV_LONG = 6'h29;
   localparam logic [5:0] DIV_SHORT = 6'h28;
   localparam logic [4:0] DIV_RUNS = 5'h18;
   localparam int CLK_MHZ = 250;
   localparam int RST_HOLD_NS = 200000;
   localparam int RST_HOLD_CYC = (RST_HOLD_NS * CLK_MHZ + 999) / 1000;
   typedef enum logic [3:0] {
      ST_IDLE, ST_ADDR, ST_AACK, ST_WORD, ST_WACK, ST_WR, ST_DACK, ST_RD, ST_RACK
   } rtc_state_t;
endpackage : rtc_pkg
